// ==== verilog/dma_channel_activation_priority.sv ====
// dma channel activation, source flag clearing and cpu priority masking
// Summary of operation
// [R1] activation field picks steal, burst, peripheral, external
// [R2] peripheral mode uses request source select register
// [R3] external mode samples per request sampling select
// [R4] flag clear enable only matters in peripheral mode
// [R5] clear enable 0 leaves peripheral flag set
// [R6] clear enable 1 clears peripheral flag on transfer
// [R7] bits four and three read zero, ignore writes
// [R8] priority field is binary level zero to seven
// [R9] cpu priority at or above channel masks request
// [R10] every channel keeps its own priority
// [R11] priority masking only when cpu control enabled
// [R12] stealing releases bus each transfer, burst keeps it
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_activation_priority
	import dma_act_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [SRC_N-1:0] periph_irq,
	output logic [SRC_N-1:0] periph_flag_clr,
	input wire logic [CH_N-1:0] ext_req_n,
	input wire logic [PRIO_W-1:0] cpu_priority,
	output logic src_rd,
	input wire logic [31:0] src_data,
	output logic bus_hold,
	output logic [CH_W-1:0] active_ch,
	output logic out_valid,
	input wire logic out_ready,
	output logic [31:0] out_data
);
	// per-channel control state and the shared cpu priority control enable
	logic [CH_N-1:0] ch_en_r; // channel armed
	logic [1:0] act_r [CH_N]; // activation source
	logic [CH_N-1:0] fce_r; // source flag clear enable
	logic [PRIO_W-1:0] prio_r [CH_N]; // channel priority level
	logic [SRC_W-1:0] src_sel_r [CH_N]; // peripheral interrupt source
	logic [CH_N-1:0] samp_r; // external sampling method
	logic [CNT_W-1:0] cnt_r [CH_N]; // words left
	logic cpu_pc_en_r; // cpu priority control enable
	// bus slave state
	logic wr_pend_r; // write data phase in progress
	logic [7:0] wr_addr_r;
	logic rd_pend_r; // read wait cycle in progress
	logic [7:0] rd_addr_r;
	logic [31:0] hrdata_r;
	logic accept;
	logic [2:0] hsize_unused;
	// transfer engine state
	xfer_state_t state_r;
	logic [CH_W-1:0] cur_r; // channel owning the bus
	logic [SRC_N-1:0] flag_clr_r; // one-cycle flag clear strobes
	logic [CH_N-1:0] ch_req; // request per channel after cpu priority masking
	logic [CH_N-1:0] ext_req; // sampled external requests
	logic [CH_N-1:0] consume; // transfer taken per channel
	logic xfer_go; // one word moves this cycle
	logic last_word;
	logic [CH_W-1:0] pick;
	logic pick_any;

	word_stream_if wbuf ();

	// decide whether cpu priority masks a channel
	function automatic logic cpu_masks(input logic en, input logic [PRIO_W-1:0] cpu,
			input logic [PRIO_W-1:0] ch);
		// binary compare of levels, higher code wins
		cpu_masks = en && (cpu >= ch); // [R8] [R9] [R11]
	endfunction

	// whether an address is the register at offset off in the block of channel c
	function automatic logic ch_hit(input logic [7:0] a, input int c, input logic [7:0] off);
		ch_hit = (a == CH_STRIDE * c[7:0] + off);
	endfunction

	// ------------------------------------------------------------
	// ahb-lite slave: writes land at the end of their data phase,
	// reads take one wait cycle so they always see committed writes
	// ------------------------------------------------------------
	assign accept = hsel && hready && htrans[1];
	assign hsize_unused = hsize; // only whole words are issued
	assign hreadyout = !rd_pend_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rd_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= accept && hwrite;
			rd_pend_r <= accept && !hwrite;
			if (accept) begin
				wr_addr_r <= haddr[7:0];
				rd_addr_r <= haddr[7:0];
			end
		end
	end

	// read data mux, loaded during the wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_pend_r) begin
			// unmapped addresses read zero
			hrdata_r <= 32'h0000_0000;
			for (int c = 0; c < CH_N; c++) begin
				if (ch_hit(rd_addr_r, c, OFF_MODE)) begin
					// bits four and three always come back zero
					hrdata_r[MODE_EN_BIT] <= ch_en_r[c];
					hrdata_r[MODE_ACT_LSB +: 2] <= act_r[c];
					hrdata_r[MODE_FCE_BIT] <= fce_r[c];
					hrdata_r[MODE_PRIO_LSB +: PRIO_W] <= prio_r[c]; // [R7]
				end
				if (ch_hit(rd_addr_r, c, OFF_SRC_SEL)) begin
					hrdata_r[SRC_SEL_LSB +: SRC_W] <= src_sel_r[c];
					hrdata_r[SRC_SAMP_BIT] <= samp_r[c];
				end
				if (ch_hit(rd_addr_r, c, OFF_COUNT)) begin
					hrdata_r[CNT_W-1:0] <= cnt_r[c];
				end
			end
			if (rd_addr_r == OFF_CPU_PC) begin
				hrdata_r[CPU_PC_EN_BIT] <= cpu_pc_en_r;
			end
			if (rd_addr_r == OFF_STATUS) begin
				hrdata_r[STAT_REQ_LSB +: CH_N] <= ch_req;
				hrdata_r[STAT_EN_LSB +: CH_N] <= ch_en_r;
				hrdata_r[STAT_HOLD_BIT] <= bus_hold;
			end
		end
	end

	// shared cpu priority control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cpu_pc_en_r <= 1'b0;
		else if (wr_pend_r && wr_addr_r == OFF_CPU_PC) cpu_pc_en_r <= hwdata[CPU_PC_EN_BIT];
	end

	// per-channel configuration, each channel with its own copy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int c = 0; c < CH_N; c++) begin
				act_r[c] <= ACT_RESET;
				prio_r[c] <= PRIO_RESET;
				src_sel_r[c] <= '0;
			end
			fce_r <= '0;
			samp_r <= '0;
		end else begin
			for (int c = 0; c < CH_N; c++) begin
				if (wr_pend_r && ch_hit(wr_addr_r, c, OFF_MODE)) begin
					// writes to bits four and three are dropped
					act_r[c] <= hwdata[MODE_ACT_LSB +: 2]; // [R1] [R7]
					fce_r[c] <= hwdata[MODE_FCE_BIT];
					prio_r[c] <= hwdata[MODE_PRIO_LSB +: PRIO_W]; // [R10]
				end
				if (wr_pend_r && ch_hit(wr_addr_r, c, OFF_SRC_SEL)) begin
					src_sel_r[c] <= hwdata[SRC_SEL_LSB +: SRC_W]; // [R2]
					samp_r[c] <= hwdata[SRC_SAMP_BIT]; // [R3]
				end
			end
		end
	end

	// enable and count: software write wins over the end-of-count clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch_en_r <= '0;
			for (int c = 0; c < CH_N; c++) cnt_r[c] <= CNT_RESET;
		end else begin
			for (int c = 0; c < CH_N; c++) begin
				if (consume[c]) begin
					cnt_r[c] <= cnt_r[c] - {{(CNT_W-1){1'b0}}, 1'b1};
					if (last_word) ch_en_r[c] <= 1'b0;
				end
				if (wr_pend_r && ch_hit(wr_addr_r, c, OFF_MODE)) begin
					ch_en_r[c] <= hwdata[MODE_EN_BIT];
				end
				if (wr_pend_r && ch_hit(wr_addr_r, c, OFF_COUNT)) begin
					cnt_r[c] <= hwdata[CNT_W-1:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// request generation
	// ------------------------------------------------------------
	for (genvar g = 0; g < CH_N; g++) begin : g_ext
		ext_request_sampler u_sampler (
			.hclk(hclk),
			.hresetn(hresetn),
			.ext_req_n(ext_req_n[g]),
			.request_sampling_sel(samp_r[g]),
			.consume(consume[g]),
			.req(ext_req[g])
		);
	end

	// raw request per activation source, then cpu priority masking
	always_comb begin
		logic raw; // request before masking, reused per channel
		raw = 1'b0;
		for (int c = 0; c < CH_N; c++) begin
			raw = 1'b0;
			case (act_r[c])
				ACT_AUTO_STEAL: raw = 1'b1; // [R1]
				ACT_AUTO_BURST: raw = 1'b1; // [R1]
				ACT_PERIPH: raw = periph_irq[src_sel_r[c]]; // [R1] [R2]
				ACT_EXT: raw = ext_req[c]; // [R1] [R3]
				default: raw = 1'b0;
			endcase
			ch_req[c] = ch_en_r[c] && (cnt_r[c] != CNT_RESET) && raw &&
				!cpu_masks(cpu_pc_en_r, cpu_priority, prio_r[c]); // [R9] [R10]
		end
	end

	// fixed arbitration: lowest channel number wins
	always_comb begin
		pick = '0;
		pick_any = 1'b0;
		for (int c = CH_N - 1; c >= 0; c--) begin
			if (ch_req[c]) begin
				pick = c[CH_W-1:0];
				pick_any = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// transfer engine
	// ------------------------------------------------------------
	assign xfer_go = (state_r == ST_XFER) && ch_req[cur_r] && wbuf.in_ready;
	assign last_word = (cnt_r[cur_r] == {{(CNT_W-1){1'b0}}, 1'b1});
	always_comb begin
		consume = '0;
		consume[cur_r] = xfer_go;
	end

	// bus ownership sequence
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			cur_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (pick_any) begin
						cur_r <= pick;
						state_r <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (!ch_req[cur_r]) begin
						// request dropped or masked: give the bus back
						state_r <= ST_RELEASE;
					end else if (xfer_go) begin
						// burst keeps the bus until the count ends
						if (act_r[cur_r] != ACT_AUTO_BURST || last_word) begin
							state_r <= ST_RELEASE; // [R12]
						end
					end
				end
				ST_RELEASE: state_r <= ST_IDLE; // [R12]
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// source flag clear strobe, only for peripheral activation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_clr_r <= '0;
		end else begin
			flag_clr_r <= '0;
			if (xfer_go && act_r[cur_r] == ACT_PERIPH && fce_r[cur_r]) begin // [R4]
				flag_clr_r[src_sel_r[cur_r]] <= 1'b1; // [R6]
			end
			// with clear enable low the flag is left for the cpu [R5]
		end
	end

	// data path through the two-entry buffer
	assign wbuf.in_valid = xfer_go;
	assign wbuf.in_data = src_data;
	assign wbuf.out_ready = out_ready;
	word_buffer u_buffer (
		.hclk(hclk),
		.hresetn(hresetn),
		.bus(wbuf.store)
	);

	// block outputs
	assign src_rd = xfer_go;
	assign bus_hold = (state_r == ST_XFER);
	assign active_ch = cur_r;
	assign periph_flag_clr = flag_clr_r;
	assign out_valid = wbuf.out_valid;
	assign out_data = wbuf.out_data;
endmodule
`default_nettype wire

// ==== include/dma_act_pkg.sv ====
// package of register map, field layout and state encodings for the dma activation block
`default_nettype none
package dma_act_pkg;
	// channel count and widths
	localparam int CH_N = 2;
	localparam int CH_W = 1;
	localparam int SRC_N = 8;
	localparam int SRC_W = 3;
	localparam int CNT_W = 16;
	localparam int PRIO_W = 3;
	// per-channel register block: byte offset of block n is n * CH_STRIDE
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_SRC_SEL = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	// shared registers
	localparam logic [7:0] OFF_CPU_PC = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	// channel_mode_control fields
	localparam int MODE_EN_BIT = 15;
	localparam int MODE_ACT_LSB = 6;
	localparam int MODE_FCE_BIT = 5;
	localparam int MODE_PRIO_LSB = 0;
	// request_source_select_reg fields
	localparam int SRC_SEL_LSB = 0;
	localparam int SRC_SAMP_BIT = 8;
	// cpu_priority_ctrl_reg fields
	localparam int CPU_PC_EN_BIT = 0;
	// status fields
	localparam int STAT_REQ_LSB = 0;
	localparam int STAT_EN_LSB = 8;
	localparam int STAT_HOLD_BIT = 16;
	// reset values
	localparam logic [1:0] ACT_RESET = 2'h0;
	localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	// activation source encodings
	localparam logic [1:0] ACT_AUTO_STEAL = 2'h0;
	localparam logic [1:0] ACT_AUTO_BURST = 2'h1;
	localparam logic [1:0] ACT_PERIPH = 2'h2;
	localparam logic [1:0] ACT_EXT = 2'h3;
	// transfer engine states
	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_RELEASE} xfer_state_t;
endpackage
`default_nettype wire

// ==== include/word_stream_if.sv ====
// interface carrying words into and out of the two-entry buffer
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if;
	logic in_valid; // engine offers a word
	logic in_ready; // buffer has room
	logic [31:0] in_data;
	logic out_valid; // buffer holds a word
	logic out_ready; // receiver takes it
	logic [31:0] out_data;
	// engine side fills and takes words from the output
	modport fill (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
	// buffer side
	modport store (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// ==== verilog/word_buffer.sv ====
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_buffer (
	input wire logic hclk,
	input wire logic hresetn,
	word_stream_if.store bus
);
	logic [31:0] mem [2]; // storage entries
	logic wr_ptr_r; // next slot to fill
	logic rd_ptr_r; // next slot to drain
	logic [1:0] fill_r; // words held
	logic push;
	logic pop;

	// honest flags from the fill count
	assign bus.in_ready = (fill_r != 2'h2);
	assign bus.out_valid = (fill_r != 2'h0);
	assign bus.out_data = mem[rd_ptr_r];
	assign push = bus.in_valid && bus.in_ready;
	assign pop = bus.out_valid && bus.out_ready;

	// entry storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem[0] <= 32'h0000_0000;
			mem[1] <= 32'h0000_0000;
		end else if (push) begin
			mem[wr_ptr_r] <= bus.in_data;
		end
	end

	// pointers and count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			fill_r <= 2'h0;
		end else begin
			if (push) wr_ptr_r <= ~wr_ptr_r;
			if (pop) rd_ptr_r <= ~rd_ptr_r;
			fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// ==== verilog/ext_request_sampler.sv ====
// synchroniser and level/edge sampler for one external request pin
`timescale 1ns/1ps
`default_nettype none
module ext_request_sampler (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ext_req_n, // asynchronous, active low
	input wire logic request_sampling_sel, // 0 low level, 1 falling edge
	input wire logic consume, // a transfer took the request
	output logic req
);
	logic meta_r; // first stage, read only by sync_r
	logic sync_r; // second stage
	logic prev_r; // previous synchronised level
	logic edge_pend_r; // latched falling edge

	// two-flop synchroniser plus history for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= ext_req_n;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// edge latch: a new edge beats a consume in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) edge_pend_r <= 1'b0;
		else if (prev_r && !sync_r) edge_pend_r <= 1'b1;
		else if (consume) edge_pend_r <= 1'b0;
	end

	// chosen sampling method decides what counts as a request
	assign req = request_sampling_sel ? edge_pend_r : !sync_r; // [R3]
endmodule
`default_nettype wire

// ==== bench/dma_act_assertions.sv ====
// checker of bus, transfer and flag timing at the block's ports
`timescale 1ns/1ps
`default_nettype none
module dma_act_checker
	import dma_act_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [SRC_N-1:0] periph_flag_clr,
	input wire logic src_rd,
	input wire logic bus_hold,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [31:0] out_data
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// read or write taken on the bus
	sequence s_rd; hsel && hready && htrans[1] && !hwrite; endsequence
	sequence s_wr; hsel && hready && htrans[1] && hwrite; endsequence
	// read data phase: one wait cycle, then ready
	sequence s_rd_phase; !hreadyout ##1 hreadyout; endsequence
	property p_rd_wait;
		s_rd |=> s_rd_phase;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read data phase timing wrong");
	property p_wr_ready;
		s_wr |=> hreadyout;
	endproperty
	a_wr_ready: assert property (p_wr_ready) else $error("write data phase stalled");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_rd_held;
		src_rd |-> bus_hold;
	endproperty
	a_rd_held: assert property (p_rd_held) else $error("word moved without the bus");
	property p_word_out;
		src_rd |=> out_valid;
	endproperty
	a_word_out: assert property (p_word_out) else $error("moved word not offered");
	property p_clr_cause;
		|periph_flag_clr |-> $past(src_rd) && $onehot(periph_flag_clr);
	endproperty
	a_clr_cause: assert property (p_clr_cause) else $error("flag clear without transfer");
	property p_clr_pulse;
		|periph_flag_clr |=> periph_flag_clr == '0;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse) else $error("flag clear too long");
	property p_release;
		$fell(bus_hold) |=> !bus_hold;
	endproperty
	a_release: assert property (p_release) else $error("bus released too briefly");
	property p_stall;
		out_valid && !out_ready |=> out_valid && $stable(out_data);
	endproperty
	a_stall: assert property (p_stall) else $error("word lost in stall");
endmodule
bind dma_channel_activation_priority dma_act_checker dma_act_checker_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.periph_flag_clr(periph_flag_clr), .src_rd(src_rd), .bus_hold(bus_hold),
	.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
`default_nettype wire

// ==== bench/periph_model.sv ====
// model of the peripherals and the word source beside the block
`timescale 1ns/1ps
`default_nettype none
module periph_model
	import dma_act_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [SRC_N-1:0] periph_flag_clr,
	input wire logic [SRC_N-1:0] flag_set,
	input wire logic [SRC_N-1:0] flag_wipe,
	output logic [SRC_N-1:0] periph_irq,
	input wire logic src_rd,
	output logic [31:0] src_data
);
	logic [7:0] seq_r; // words handed out so far
	// flags rise on an event, fall on a dma clear or on cpu service
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) periph_irq <= '0;
		else periph_irq <= (periph_irq | flag_set) & ~periph_flag_clr & ~flag_wipe;
	end
	// source steps to a fresh word after each read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) seq_r <= 8'h00;
		else if (src_rd) seq_r <= seq_r + 8'h01;
	end
	assign src_data = {24'h5A0000, seq_r};
endmodule
`default_nettype wire

// ==== bench/dma_channel_activation_priority_bench.sv ====
// self-checking bench for the dma activation block
`timescale 1ns/1ps
`default_nettype none
module dma_channel_activation_priority_bench;
	import dma_act_pkg::*;
	// register access: write flag, address, data, value read back
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic out_ready = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] ext_req_n = 2'h3;
	logic [2:0] cpu_priority = 3'h0;
	logic [7:0] flag_set = 8'h00;
	logic [7:0] flag_wipe = 8'h00;
	wire hreadyout, hresp, src_rd, bus_hold, out_valid;
	wire [31:0] hrdata, src_data, out_data;
	wire [7:0] periph_irq, periph_flag_clr;
	wire [0:0] active_ch;
	logic hr_s, bh_q;
	logic [31:0] rd_s, v;
	int failures = 0, num_checks = 0, rx = 0, seq = 0, falls = 0, cyc = 0;
	row_t rows [6] = '{'{1'b1, 8'h00, 32'h000000FF, 32'h000000E7},
		'{1'b1, 8'h10, 32'h00000005, 32'h00000005}, '{1'b0, 8'h00, 32'h0, 32'h000000E7},
		'{1'b1, 8'h04, 32'h000001FF, 32'h00000107}, '{1'b1, 8'h20, 32'hFFFFFFFF, 32'h1},
		'{1'b1, 8'h30, 32'h0000FFFF, 32'h0}};
	logic [7:0] rst_a [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h24};
	always #12.5 hclk = ~hclk;
	dma_channel_activation_priority dma_channel_activation_priority_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periph_irq(periph_irq),
		.periph_flag_clr(periph_flag_clr), .ext_req_n(ext_req_n),
		.cpu_priority(cpu_priority), .src_rd(src_rd), .src_data(src_data),
		.bus_hold(bus_hold), .active_ch(active_ch), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data));
	periph_model periph_model_inst (.hclk(hclk), .hresetn(hresetn),
		.periph_flag_clr(periph_flag_clr), .flag_set(flag_set), .flag_wipe(flag_wipe),
		.periph_irq(periph_irq), .src_rd(src_rd), .src_data(src_data));
	// bus answers captured mid-cycle, so the next rising edge sees settled values
	always @(negedge hclk) begin
		hr_s = hreadyout;
		rd_s = hrdata;
	end
	// receiver, release counter and hang guard (run needs well under 2000 cycles)
	always @(posedge hclk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			chk("out_data", out_data, {24'h5A0000, seq[7:0]});
			seq++;
			rx++;
		end
		if (bh_q === 1'b1 && bus_hold === 1'b0) falls++;
		bh_q = bus_hold;
		cyc++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// one rising edge at which the slave is ready
	task automatic edge_rdy;
		do @(posedge hclk); while (hr_s !== 1'b1);
	endtask
	// single word transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		edge_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= w ? d : 32'h0;
		edge_rdy();
		q = rd_s;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, v);
		chk($sformatf("reg %h", a), v, e);
	endtask
	task automatic wait_rx(input int n);
		while (rx < n) @(posedge hclk);
		// a few idle edges more, so a word beyond the expected count shows up
		repeat (4) @(posedge hclk);
		chk("words", rx, n);
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
		rx = 0;
		falls = 0;
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rst_a[i]) rdc(rst_a[i], 32'h0);
		done("reset");
		foreach (rows[i]) begin
			if (rows[i].wr) xfer(1'b1, rows[i].a, rows[i].d, v);
			rdc(rows[i].a, rows[i].e);
		end
		done("registers");
		// stealing, clear enable set, cpu level high but control off
		xfer(1'b1, 8'h20, 32'h0, v);
		cpu_priority <= 3'h7;
		flag_set <= 8'h08;
		xfer(1'b1, 8'h04, 32'h3, v);
		flag_set <= 8'h00;
		xfer(1'b1, 8'h08, 32'h2, v);
		xfer(1'b1, 8'h00, 32'h00008020, v);
		wait_rx(2);
		rdc(8'h00, 32'h00000020);
		chk("falls", falls, 2);
		chk("flag kept", periph_irq[3], 1'b1);
		done("steal");
		// peripheral trigger only from the selected source, cleared by the transfer
		flag_wipe <= 8'h08;
		flag_set <= 8'h20;
		xfer(1'b1, 8'h08, 32'h1, v);
		flag_wipe <= 8'h00;
		xfer(1'b1, 8'h00, 32'h000080A0, v);
		rdc(8'h08, 32'h1);
		flag_set <= 8'h08;
		@(posedge hclk);
		flag_set <= 8'h00;
		wait_rx(1);
		rdc(8'h08, 32'h0);
		chk("flags", periph_irq, 8'h20);
		done("periph clear");
		// clear enable off: flag waits for cpu service
		xfer(1'b1, 8'h08, 32'h1, v);
		xfer(1'b1, 8'h00, 32'h00008080, v);
		flag_set <= 8'h08;
		@(posedge hclk);
		flag_set <= 8'h00;
		wait_rx(1);
		rdc(8'h08, 32'h0);
		chk("flags", periph_irq, 8'h28);
		flag_wipe <= 8'hFF;
		@(posedge hclk);
		flag_wipe <= 8'h00;
		done("periph keep");
		// channel one: edge sampling gives one word per fall, level keeps asking
		xfer(1'b1, 8'h14, 32'h100, v);
		xfer(1'b1, 8'h18, 32'h2, v);
		xfer(1'b1, 8'h10, 32'h000080C0, v);
		ext_req_n <= 2'h1;
		wait_rx(1);
		rdc(8'h18, 32'h1);
		chk("channel", active_ch, 1'b1);
		chk("words", rx, 1);
		ext_req_n <= 2'h3;
		xfer(1'b1, 8'h14, 32'h0, v);
		ext_req_n <= 2'h1;
		wait_rx(2);
		ext_req_n <= 2'h3;
		rdc(8'h18, 32'h0);
		done("external");
		// channel level equal to cpu level is masked, lower cpu level lets it run
		xfer(1'b1, 8'h20, 32'h1, v);
		cpu_priority <= 3'h2;
		xfer(1'b1, 8'h08, 32'h1, v);
		xfer(1'b1, 8'h00, 32'h00008002, v);
		rdc(8'h08, 32'h1);
		rdc(8'h24, 32'h00000100);
		cpu_priority <= 3'h1;
		wait_rx(1);
		done("priority");
		// burst keeps the bus through a receiver stall
		xfer(1'b1, 8'h20, 32'h0, v);
		out_ready <= 1'b0;
		xfer(1'b1, 8'h08, 32'h3, v);
		xfer(1'b1, 8'h00, 32'h00008040, v);
		rdc(8'h24, 32'h00010101);
		rdc(8'h08, 32'h1);
		chk("full", out_valid, 1'b1);
		chk("falls", falls, 0);
		out_ready <= 1'b1;
		wait_rx(3);
		rdc(8'h08, 32'h0);
		chk("falls", falls, 1);
		done("burst");
		conclude();
	end
endmodule
`default_nettype wire
